// ---- phy_mii_rmii_mac_side_port_tb_top.sv ----
// self-checking bench of the mac-side data port
`timescale 1ns/1ps
module phy_mii_rmii_mac_side_port_tb_top;
  import pmp_pkg::*;
  // ==========================================================================
  // signals
  // ==========================================================================
  logic         mclk_i, srst_i, strap, rx_v, carrier, rdy, stalled, rclk_q, late;
  logic         rx_clk, rx_dv, crs, rx_er, col, tx_clk, tx_en, nv, tx_act, rmode, mcol;
  logic [3:0]   rxd, txd, nib;
  pmp_cfg_t     cfg;
  pmp_rx_item_t item;
  logic [4:0]   rxq[$];
  logic [3:0]   txq[$];
  int           errors, num_checks, colcnt, clkhi, dvnocrs, ph, s;

  pmp_mac_port #(.BUF_DEPTH(2)) dut_u (
    .mclk_i(mclk_i), .srst_i(srst_i), .rmii_strap_i(strap), .cfg_i(cfg),
    .rx_item_i(item), .rx_item_valid_i(rx_v), .rx_item_ready_o(rdy),
    .rx_carrier_i(carrier), .rx_clk_o(rx_clk), .rxd_o(rxd), .rx_dv_o(rx_dv),
    .crs_o(crs), .rx_er_o(rx_er), .col_o(col), .tx_clk_o(tx_clk), .tx_en_i(tx_en),
    .txd_i(txd), .tx_nibble_o(nib), .tx_nibble_valid_o(nv), .tx_active_o(tx_act),
    .rmii_mode_o(rmode));

  pmp_mac_model mac_u (
    .mclk_i(mclk_i), .rmii_i(rmode), .speed100_i(cfg.speed100), .tx_clk_i(tx_clk),
    .nib_valid_i(nv), .crs_i(crs), .tx_en_o(tx_en), .txd_o(txd), .mac_col_o(mcol),
    .late_o(late));

  // ==========================================================================
  // clock and monitors
  // ==========================================================================
  initial begin
    mclk_i = 1'b0;
    // one ideal reference stands in for the 25 or 50 MHz source of either mode
    forever #2.5 mclk_i = ~mclk_i;
  end
  // mii data taken at rx clock rise, rmii mid dibit
  always @(posedge mclk_i) begin
    rclk_q <= rx_clk;
    ph <= rx_dv ? ((ph == s - 1) ? 0 : ph + 1) : 0;
    if (rx_dv && (rmode ? ph == s / 2 : rx_clk && !rclk_q)) rxq.push_back({rx_er, rxd});
    if (nv) txq.push_back(nib);
    // unknown levels count as high so they cannot hide in an int
    colcnt <= colcnt + int'(col !== 1'b0);
    clkhi <= clkhi + int'((rx_clk !== 1'b0) || (tx_clk !== 1'b0));
    dvnocrs <= dvnocrs + int'(rx_dv & !crs);
  end

  // ==========================================================================
  // checking and closing
  // ==========================================================================
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic tmo(input string what);
    errors++;
    $display("Error %s expected done seen timeout", what);
    print_verdict();
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic rst(input logic rm, input logic [2:0] c);
    srst_i <= 1'b1;
    strap <= rm;
    cfg <= c;
    s = 2 * int'(RMII_HALF) * (c[2] ? 1 : 10);
    repeat (4) @(posedge mclk_i);
    srst_i <= 1'b0;
    strap <= ~rm;
    repeat (3) @(posedge mclk_i);
    chk("rmii_mode", 16'(rm), 16'(rmode));
  endtask

  task automatic per(input logic sel, input int exp);
    int n;
    int r;
    logic p;
    logic c;
    n = 0;
    r = 0;
    p = 1'b1;
    for (int i = 0; i < 400 && r < 2; i++) begin
      @(posedge mclk_i);
      c = sel ? tx_clk : rx_clk;
      if (c === 1'b1 && p === 1'b0) r++;
      if (r == 1) n++;
      p = c;
    end
    if (r < 2) tmo("clk_edges");
    chk(sel ? "tx_clk_period" : "rx_clk_period", 16'(exp), 16'(n));
  endtask

  // line side keeps valid until taken; idle data is inverted, not held
  task automatic feed(input logic [4:0] v[$]);
    int t;
    foreach (v[i]) begin
      rx_v <= 1'b1;
      item <= v[i];
      t = 0;
      do begin
        @(posedge mclk_i);
        t++;
        if (rdy === 1'b0) stalled = 1'b1;
      end while (rdy !== 1'b1 && t < 2000);
      if (t >= 2000) tmo("rx_ready");
    end
    rx_v <= 1'b0;
    item <= ~item;
  endtask

  task automatic rx_run(input logic rm, input logic sp);
    logic [4:0] v[$];
    logic [4:0] ex[$];
    logic [3:0] d;
    int c0;
    int t;
    v = '{5'h06, 5'h13, 5'h18, 5'h0C, 5'h1D};
    rxq.delete();
    stalled = 1'b0;
    c0 = dvnocrs;
    carrier <= 1'b1;
    // rmii carrier sense only moves at a dibit slot, up to one slot late
    repeat (rm ? s + 4 : 3) @(posedge mclk_i);
    chk("crs", 16'h1, 16'(crs));
    feed(v);
    carrier <= 1'b0;
    t = 0;
    while (rx_dv !== 1'b0 && t < 2000) begin
      @(posedge mclk_i);
      t++;
    end
    if (t >= 2000) tmo("rx_idle");
    repeat (4) @(posedge mclk_i);
    chk("crs", 16'h0, 16'(crs));
    chk("rx_stall", 16'h1, 16'(stalled));
    chk("dv_without_crs", 16'h1, 16'(dvnocrs != c0));
    foreach (v[i]) begin
      d = v[i][4:1] ^ (v[i][0] ? CORRUPT_MASK : 4'h0);
      if (rm) begin
        ex.push_back({v[i][0] & sp, 2'b00, d[1:0]});
        ex.push_back({v[i][0] & sp, 2'b00, d[3:2]});
      end else begin
        ex.push_back({v[i][0] & sp, d});
      end
    end
    chk("rx_count", 16'(ex.size()), 16'(rxq.size()));
    foreach (ex[i]) chk("rx_item", 16'(ex[i]), 16'(rxq[i]));
  endtask

  task automatic tx_run(input logic ec, input logic em, input int en);
    logic [3:0] q[$];
    int c0;
    int t;
    q = '{4'h5, 4'h3, 4'hC, 4'h9};
    c0 = colcnt;
    txq.delete();
    fork
      mac_u.send(q);
      begin
        t = 0;
        while (tx_act !== 1'b1 && t < 1000) begin
          @(posedge mclk_i);
          t++;
        end
        if (t >= 1000) tmo("tx_active");
        repeat (4) @(posedge mclk_i);
        chk("col", 16'(ec), 16'(col));
        chk("mac_col", 16'(em), 16'(mcol));
      end
    join
    repeat (300) @(posedge mclk_i);
    if (late === 1'b1) tmo("mac_step");
    chk("tx_active", 16'h0, 16'(tx_act));
    chk("tx_count", 16'(q.size()), 16'(txq.size()));
    foreach (q[i]) chk("tx_nibble", 16'(q[i]), 16'(txq[i]));
    if (en >= 0) chk("col_cycles", 16'(en), 16'(colcnt - c0));
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    int c0;
    errors = 0;
    num_checks = 0;
    colcnt = 0;
    clkhi = 0;
    dvnocrs = 0;
    ph = 0;
    s = 4;
    srst_i = 1'b1;
    strap = 1'b0;
    cfg = 3'h0;
    rx_v = 1'b0;
    item = 5'h00;
    carrier = 1'b0;
    rst(1'b0, 3'h5);
    per(1'b0, 2 * MII100_HALF);
    per(1'b1, 2 * MII100_HALF);
    rx_run(1'b0, 1'b1);
    carrier <= 1'b1;
    tx_run(1'b1, 1'b0, -1);
    rst(1'b0, 3'h7);
    tx_run(1'b0, 1'b0, 0);
    carrier <= 1'b0;
    rst(1'b0, 3'h1);
    per(1'b0, 2 * MII10_HALF);
    per(1'b1, 2 * MII10_HALF);
    tx_run(1'b0, 1'b0, SQE_CYCLES);
    rx_run(1'b0, 1'b0);
    rst(1'b0, 3'h3);
    tx_run(1'b0, 1'b0, 0);
    // heartbeat switched off: 10M half duplex must stay quiet after the frame
    rst(1'b0, 3'h0);
    tx_run(1'b0, 1'b0, 0);
    rst(1'b1, 3'h5);
    c0 = clkhi;
    rx_run(1'b1, 1'b1);
    carrier <= 1'b1;
    tx_run(1'b0, 1'b1, 0);
    carrier <= 1'b0;
    rst(1'b1, 3'h1);
    rx_run(1'b1, 1'b0);
    tx_run(1'b0, 1'b0, 0);
    chk("mii_clk_high", 16'h0, 16'(clkhi - c0));
    print_verdict();
  end
endmodule

// ---- pmp_mac_model.sv ----
// mac model driving the transmit side of the data port
`timescale 1ns/1ps
module pmp_mac_model
  import pmp_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rmii_i,
  input  wire logic       speed100_i,
  input  wire logic       tx_clk_i,
  input  wire logic       nib_valid_i,
  input  wire logic       crs_i,
  output logic            tx_en_o,
  output logic [3:0]      txd_o,
  output logic            mac_col_o,
  output logic            late_o
);
  // ==========================================================================
  // transmit clock tracking
  // ==========================================================================
  logic clk_q;
  initial begin
    tx_en_o = 1'b0;
    txd_o = 4'h0;
    late_o = 1'b0;
  end
  always @(posedge mclk_i) begin
    clk_q <= tx_clk_i;
  end
  // no collision pin in rmii, so carrier plus own enable stands in
  assign mac_col_o = rmii_i & crs_i & tx_en_o;

  // ==========================================================================
  // frame sender
  // ==========================================================================
  task automatic step(input logic rise);
    int t;
    t = 0;
    do begin
      @(posedge mclk_i);
      t++;
    end while ((rise ? !(tx_clk_i && !clk_q) : !nib_valid_i) && t < 1000);
    // a lost clock or nibble must not pass silently
    if (t >= 1000) late_o <= 1'b1;
  endtask

  // first rmii nibble needs equal dibits: the sample phase is not visible
  task automatic send(input logic [3:0] nib[$]);
    int s;
    s = 2 * int'(RMII_HALF) * (speed100_i ? 1 : 10);
    foreach (nib[i]) begin
      if (!rmii_i) begin
        step(1'b1);
        tx_en_o <= 1'b1;
        txd_o <= nib[i];
      end else begin
        if (i == 0) @(posedge mclk_i);
        tx_en_o <= 1'b1;
        txd_o <= {~nib[i][3:2], nib[i][1:0]};
        if (i > 0) begin
          repeat (s - 1) @(posedge mclk_i);
          txd_o <= {~nib[i][1:0], nib[i][3:2]};
        end
        step(1'b0);
      end
    end
    if (!rmii_i) step(1'b1);
    tx_en_o <= 1'b0;
    txd_o <= ~txd_o;
  endtask
endmodule

// ---- pmp_mac_port.sv ----
// mac-facing mii / rmii data port of a 10/100 transceiver
// How it works
// - mii half duplex: collision output high while transmit and receive overlap
// - mii 10M half duplex with heartbeat: about 1 us collision pulse after transmit
// - full duplex: collision held low, no heartbeat pulse
// - mii: carrier sense high while receive medium is busy
// - rmii: carrier sense pin carries combined crs_dv
// - mii receive clock at 25 MHz or 2.5 MHz by speed
// - rmii: mii clocks unused, both directions timed by 50 MHz reference
// - mii: rx_dv high exactly while nibble data valid
// - rmii: separate rx data valid independent of carrier sense
// - mii 100M: receive error on invalid symbol in packet
// - rmii 100M: receive error on media error while data valid
// - receive error also corrupts the data passed to the mac
// - mii: one nibble per receive clock, valid only with rx_dv
// - rmii: two bits per reference clock at 100M, each held 10 clocks at 10M, on the low data lines
// - mii transmit clock at 25 MHz or 2.5 MHz from reference
// - mii: mac drives nibble on transmit clock, device samples on it
// - rmii: mac drives dibits on reference, device samples on it
// - mode strap sampled during reset fixes mii or rmii
`timescale 1ns/1ps
module pmp_mac_port
  import pmp_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic         mclk_i,
  input  wire logic         srst_i,
  input  wire logic         rmii_strap_i,
  input  pmp_cfg_t          cfg_i,
  input  pmp_rx_item_t      rx_item_i,
  input  wire logic         rx_item_valid_i,
  output logic              rx_item_ready_o,
  input  wire logic         rx_carrier_i,
  output logic              rx_clk_o,
  output logic [3:0]        rxd_o,
  output logic              rx_dv_o,
  output logic              crs_o,
  output logic              rx_er_o,
  output logic              col_o,
  output logic              tx_clk_o,
  input  wire logic         tx_en_i,
  input  wire logic [3:0]   txd_i,
  output logic [3:0]        tx_nibble_o,
  output logic              tx_nibble_valid_o,
  output logic              tx_active_o,
  output logic              rmii_mode_o
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  logic         rmii_mode_q;
  pmp_cfg_t     cfg_q;
  logic         carrier_q;
  logic [6:0]   div_cnt_q;
  logic         div_clk_q;
  logic [6:0]   half_cnt;
  logic         div_wrap;
  logic         rise_tick;
  logic         fall_tick;
  pmp_rx_item_t buf_item;
  logic         buf_valid;
  logic         rx_take;
  logic [3:0]   rx_cur_q;
  logic         rx_phase_q;
  logic [3:0]   rx_rep_q;
  logic [3:0]   rxd_q;
  logic         rx_dv_q;
  logic         rx_er_q;
  logic         crs_q;
  logic         tx_en_q;
  logic         tx_phase_q;
  logic [3:0]   tx_rep_q;
  logic [1:0]   tx_lo_q;
  logic [3:0]   tx_nib_q;
  logic         tx_nib_vld_q;
  logic [7:0]   sqe_q;
  logic         sqe_start;
  logic         mii_hdx;
  logic         col_q;

  function automatic logic [3:0] spoil(input pmp_rx_item_t it);
    return it.err ? (it.data ^ CORRUPT_MASK) : it.data;
  endfunction

  // ==========================================================================
  // strap and configuration
  // ==========================================================================
  // strap is caught while reset is held, then frozen until the next reset
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rmii_mode_q <= rmii_strap_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cfg_q     <= '0;
      carrier_q <= 1'b0;
    end else begin
      cfg_q     <= cfg_i;
      carrier_q <= rx_carrier_i;
    end
  end

  assign rmii_mode_o = rmii_mode_q;

  // ==========================================================================
  // clock divider
  // ==========================================================================
  // mclk stands in for the primary reference; all interface timing is tick based
  assign half_cnt  = pmp_half_period(rmii_mode_q, cfg_q.speed100);
  assign div_wrap  = (div_cnt_q >= 7'(half_cnt - 1'b1));
  assign rise_tick = div_wrap & ~div_clk_q;
  assign fall_tick = div_wrap & div_clk_q;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      div_cnt_q <= '0;
      div_clk_q <= 1'b0;
    end else if (div_wrap) begin
      div_cnt_q <= '0;
      div_clk_q <= ~div_clk_q;
    end else begin
      div_cnt_q <= 7'(div_cnt_q + 1'b1);
    end
  end

  // in rmii the mac uses the reference directly, so both clock pins rest low
  assign rx_clk_o = div_clk_q & ~rmii_mode_q;
  assign tx_clk_o = div_clk_q & ~rmii_mode_q;

  // ==========================================================================
  // receive buffer
  // ==========================================================================
  // the mac cannot stall, so the drain follows the clock and back-pressure
  // reaches the line side through rx_item_ready_o
  assign rx_take = fall_tick & (rmii_mode_q ? ((rx_rep_q == 4'h0) & ~rx_phase_q) : 1'b1);

  pmp_skid_buf #(
    .WIDTH ($bits(pmp_rx_item_t)),
    .DEPTH (BUF_DEPTH)
  ) u_rx_buf (
    .mclk_i      (mclk_i),
    .srst_i      (srst_i),
    .in_data_i   (rx_item_i),
    .in_valid_i  (rx_item_valid_i),
    .in_ready_o  (rx_item_ready_o),
    .out_data_o  (buf_item),
    .out_valid_o (buf_valid),
    .out_ready_i (rx_take)
  );

  // ==========================================================================
  // receive drive
  // ==========================================================================
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rxd_q      <= '0;
      rx_dv_q    <= 1'b0;
      rx_er_q    <= 1'b0;
      crs_q      <= 1'b0;
      rx_cur_q   <= '0;
      rx_phase_q <= 1'b0;
      rx_rep_q   <= '0;
    end else begin
      if (!rmii_mode_q) begin
        crs_q <= carrier_q;
      end
      if (fall_tick && !rmii_mode_q) begin
        if (buf_valid) begin
          rxd_q   <= spoil(buf_item);
          rx_dv_q <= 1'b1;
          rx_er_q <= buf_item.err & cfg_q.speed100;
        end else begin
          rxd_q   <= '0;
          rx_dv_q <= 1'b0;
          rx_er_q <= 1'b0;
        end
      end else if (fall_tick && rmii_mode_q) begin
        if (rx_rep_q != 4'h0) begin
          // 10M rmii repeats each dibit for several reference cycles
          rx_rep_q <= 4'(rx_rep_q - 1'b1);
        end else begin
          rx_rep_q <= 4'(pmp_rep_load(cfg_q.speed100) - 1'b1);
          if (rx_phase_q) begin
            rxd_q      <= {2'h0, rx_cur_q[3:2]};
            rx_phase_q <= 1'b0;
            crs_q      <= 1'b1;
          end else if (buf_valid) begin
            rx_cur_q   <= spoil(buf_item);
            rxd_q      <= spoil(buf_item) & 4'h3;
            rx_phase_q <= 1'b1;
            rx_dv_q    <= 1'b1;
            rx_er_q    <= buf_item.err & cfg_q.speed100;
            // after carrier drops crs_dv toggles on nibble boundaries
            crs_q      <= carrier_q;
          end else begin
            rxd_q   <= '0;
            rx_dv_q <= 1'b0;
            rx_er_q <= 1'b0;
            crs_q   <= carrier_q;
          end
        end
      end
    end
  end

  assign rxd_o   = rxd_q;
  assign rx_dv_o = rx_dv_q;
  assign rx_er_o = rx_er_q;
  assign crs_o   = crs_q;

  // ==========================================================================
  // transmit sample
  // ==========================================================================
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tx_en_q      <= 1'b0;
      tx_phase_q   <= 1'b0;
      tx_rep_q     <= '0;
      tx_lo_q      <= '0;
      tx_nib_q     <= '0;
      tx_nib_vld_q <= 1'b0;
    end else begin
      tx_en_q      <= tx_en_i;
      tx_nib_vld_q <= 1'b0;
      if (rise_tick) begin
        if (!tx_en_i) begin
          tx_phase_q <= 1'b0;
          tx_rep_q   <= '0;
        end else if (!rmii_mode_q) begin
          tx_nib_q     <= txd_i;
          tx_nib_vld_q <= 1'b1;
        end else if (tx_rep_q != 4'h0) begin
          tx_rep_q <= 4'(tx_rep_q - 1'b1);
        end else begin
          tx_rep_q <= 4'(pmp_rep_load(cfg_q.speed100) - 1'b1);
          if (!tx_phase_q) begin
            tx_lo_q    <= txd_i[1:0];
            tx_phase_q <= 1'b1;
          end else begin
            tx_nib_q     <= {txd_i[1:0], tx_lo_q};
            tx_nib_vld_q <= 1'b1;
            tx_phase_q   <= 1'b0;
          end
        end
      end
    end
  end

  assign tx_nibble_o       = tx_nib_q;
  assign tx_nibble_valid_o = tx_nib_vld_q;
  assign tx_active_o       = tx_en_q;

  // ==========================================================================
  // collision and heartbeat
  // ==========================================================================
  // rmii has no collision pin, so col_o rests low there
  assign mii_hdx   = ~rmii_mode_q & ~cfg_q.full_duplex;
  assign sqe_start = tx_en_q & ~tx_en_i & mii_hdx & ~cfg_q.speed100 & cfg_q.heartbeat_en;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sqe_q <= '0;
      col_q <= 1'b0;
    end else begin
      if (!mii_hdx) begin
        sqe_q <= '0;
      end else if (sqe_start) begin
        sqe_q <= SQE_CYCLES;
      end else if (sqe_q != 8'h00) begin
        sqe_q <= 8'(sqe_q - 1'b1);
      end
      col_q <= mii_hdx & ((tx_en_q & carrier_q) | (sqe_q != 8'h00));
    end
  end

  assign col_o = col_q;

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  col_fdx_low_a: assert property (cfg_q.full_duplex |=> !col_o)
    else $error("collision seen in full duplex");
  col_overlap_a: assert property (mii_hdx && tx_en_q && carrier_q |=> col_o)
    else $error("overlap without collision");
  sqe_pulse_a: assert property (sqe_start |=> ##1 col_o[*8])
    else $error("heartbeat pulse missing");
  rmii_clk_low_a: assert property (rmii_mode_q |-> !rx_clk_o && !tx_clk_o)
    else $error("mii clock toggles in rmii");
  rx_clk_rate_a: assert property ($rose(rx_clk_o) && cfg_q.speed100 |-> rx_clk_o[*4] ##1 !rx_clk_o)
    else $error("receive clock not 25 MHz");
  tx_clk_slow_a: assert property ($rose(tx_clk_o) && !cfg_q.speed100 |-> tx_clk_o[*8])
    else $error("transmit clock too fast at 10M");
  crs_mii_a: assert property (!rmii_mode_q && carrier_q |=> crs_o)
    else $error("carrier sense missing");
  rxer_speed_a: assert property (rx_er_o && $stable(cfg_q) |-> cfg_q.speed100)
    else $error("receive error at 10M");
  rx_corrupt_a: assert property (rx_take && buf_valid && !rmii_mode_q && buf_item.err
                                 |=> rxd_o == ($past(buf_item.data) ^ CORRUPT_MASK))
    else $error("errored nibble not corrupted");
  rxdv_idle_a: assert property (rx_take && !buf_valid && !rmii_mode_q |=> !rx_dv_o)
    else $error("rx_dv high without data");
  tx_ignore_a: assert property (tx_nibble_valid_o |-> $past(tx_en_i))
    else $error("nibble taken with tx_en low");
  strap_hold_a: assert property (!$past(srst_i) |-> $stable(rmii_mode_q))
    else $error("mode changed outside reset");

  col_seen_c:  cover property (mii_hdx && tx_en_q && carrier_q ##1 col_o);
  sqe_seen_c:  cover property (sqe_start);
  rmii_rx_c:   cover property (rmii_mode_q && rx_take && buf_valid);
  tx_nibble_c: cover property (tx_nibble_valid_o);

endmodule

// ---- pmp_pkg.sv ----
// shared constants, types and helpers of the mac-side data port
package pmp_pkg;

  // ==========================================================================
  // clock and timing
  // ==========================================================================
  localparam int MCLK_PERIOD_PS  = 5000;
  localparam int MII100_PERIOD_PS = 40000;
  localparam int MII10_PERIOD_PS  = 400000;
  localparam int RMII_PERIOD_PS   = 20000;
  localparam int SQE_TIME_NS      = 1000;

  localparam logic [6:0] MII100_HALF  = 7'(MII100_PERIOD_PS / MCLK_PERIOD_PS / 2);
  localparam logic [6:0] MII10_HALF   = 7'(MII10_PERIOD_PS / MCLK_PERIOD_PS / 2);
  localparam logic [6:0] RMII_HALF    = 7'(RMII_PERIOD_PS / MCLK_PERIOD_PS / 2);
  localparam logic [7:0] SQE_CYCLES   = 8'((SQE_TIME_NS * 1000) / MCLK_PERIOD_PS);

  // ==========================================================================
  // rmii dibit repetition and data corruption
  // ==========================================================================
  localparam logic [3:0] RMII_REP_100M = 4'h1;
  localparam logic [3:0] RMII_REP_10M  = 4'hA;
  localparam logic [3:0] CORRUPT_MASK  = 4'hF;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef struct packed {
    logic speed100;
    logic full_duplex;
    logic heartbeat_en;
  } pmp_cfg_t;

  typedef struct packed {
    logic [3:0] data;
    logic       err;
  } pmp_rx_item_t;

  function automatic logic [6:0] pmp_half_period(input logic rmii, input logic speed100);
    if (rmii) begin
      return RMII_HALF;
    end
    return speed100 ? MII100_HALF : MII10_HALF;
  endfunction

  function automatic logic [3:0] pmp_rep_load(input logic speed100);
    return speed100 ? RMII_REP_100M : RMII_REP_10M;
  endfunction

endpackage

// ---- pmp_skid_buf.sv ----
// small fifo with valid/ready on both sides
`timescale 1ns/1ps
module pmp_skid_buf #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 2
) (
  input  wire logic             mclk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [CW-1:0]    cnt_q;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // ==========================================================================
  // handshakes
  // ==========================================================================
  assign in_ready_o  = (cnt_q != CW'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // ==========================================================================
  // storage and pointers
  // ==========================================================================
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= next_ptr(wr_q);
      end
      if (pop) begin
        rd_q <= next_ptr(rd_q);
      end
      unique case ({push, pop})
        2'b10:   cnt_q <= CW'(cnt_q + 1'b1);
        2'b01:   cnt_q <= CW'(cnt_q - 1'b1);
        default: cnt_q <= cnt_q;
      endcase
    end
  end

endmodule
